// ### core/tcs_pkg.sv
// package for the timer clock select and prescaler block
// assumes a single system clock; all rates are one-cycle enables
package tcs_pkg;
  // register map (index of each register on the plain port)
  localparam logic [3:0] ADDR_CLK_CTRL = 4'h0;
  localparam logic [3:0] ADDR_EXT_CTRL = 4'h1;
  localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
  // field positions of timer_clock_control
  localparam int BIT_T3_HIGH = 7;
  localparam int BIT_T3_LOW = 6;
  localparam int BIT_T2_HIGH = 5;
  localparam int BIT_T2_LOW = 4;
  localparam int BIT_T1 = 3;
  localparam int BIT_T0 = 2;
  localparam int BIT_SCALE_HI = 1;
  localparam int BIT_SCALE_LO = 0;
  // field positions of the extra mode register
  localparam int BIT_T0_CNT = 0;
  localparam int BIT_T1_CNT = 1;
  localparam int BIT_T2_SPLIT = 2;
  localparam int BIT_T3_SPLIT = 3;
  localparam int BIT_T2_ALT = 4;
  localparam int BIT_T3_ALT = 5;
  // prescale codes and divide ratios
  localparam logic [1:0] SCALE_DIV12 = 2'h0;
  localparam logic [1:0] SCALE_DIV4 = 2'h1;
  localparam logic [1:0] SCALE_DIV48 = 2'h2;
  localparam logic [5:0] DIV_12 = 6'h0c;
  localparam logic [5:0] DIV_4 = 6'h04;
  localparam logic [5:0] DIV_48 = 6'h30;
  localparam logic [5:0] DIV_EXT = 6'h08;

  typedef struct packed {
    logic t3_high;
    logic t3_low;
    logic t2_high;
    logic t2_low;
    logic t1;
    logic t0;
  } tcs_tick_t;
endpackage : tcs_pkg

// ### core/tcs_divider.sv
// free-running divider: one-cycle tick every ratio cycles of its enable
// assumes ratio is at least 1 and changes only between ticks are tolerated
`timescale 1ns/1ps
module tcs_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control
  input wire logic step_en,
  input wire logic [5:0] ratio,
  // output
  output logic tick
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic tick_d;
  logic tick_q;

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (step_en) begin
      // a shrinking ratio wraps at once rather than running to 63
      if (cnt_q >= ratio - 6'h01) begin
        cnt_d = 6'h00;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : tcs_divider

// ### core/tcs_clock_select.sv
// timer clock select and prescaler: control register plus per-timer tick enables
// assumes a plain register port and an external oscillator input sampled on ref_clk
`timescale 1ns/1ps
module tcs_clock_select (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // external oscillator, already synchronous
  input wire logic ext_osc,
  // tick enables to the timers
  output tcs_pkg::tcs_tick_t tick,
  output logic prescale_tick
);
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [5:0] ext_q;
  logic [5:0] ext_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic osc_q;
  logic [5:0] pre_ratio;
  logic pre_tick;
  logic div12_tick;
  logic ext_tick;
  logic ext_edge;
  logic alt2;
  logic alt3;
  tcs_pkg::tcs_tick_t tick_d;
  tcs_pkg::tcs_tick_t tick_q;

  // register file
  always_comb begin
    ctrl_d = ctrl_q;
    ext_d = ext_q;
    rdata_d = 8'h00;
    if (wr_en && addr == tcs_pkg::ADDR_CLK_CTRL) begin
      ctrl_d = wdata;
    end
    if (wr_en && addr == tcs_pkg::ADDR_EXT_CTRL) begin
      ext_d = wdata[5:0];
    end
    if (rd_en) begin
      unique case (addr)
        tcs_pkg::ADDR_CLK_CTRL: rdata_d = ctrl_q;
        tcs_pkg::ADDR_EXT_CTRL: rdata_d = {2'h0, ext_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_q <= tcs_pkg::CLK_CTRL_RESET;
      ext_q <= tcs_pkg::EXT_CTRL_RESET[5:0];
      rdata_q <= 8'h00;
      osc_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ext_q <= ext_d;
      rdata_q <= rdata_d;
      osc_q <= ext_osc;
    end
  end

  assign rdata = rdata_q;

  // shared prescaler
  always_comb begin
    unique case (ctrl_q[tcs_pkg::BIT_SCALE_HI:tcs_pkg::BIT_SCALE_LO])
      tcs_pkg::SCALE_DIV12: pre_ratio = tcs_pkg::DIV_12;
      tcs_pkg::SCALE_DIV4: pre_ratio = tcs_pkg::DIV_4;
      tcs_pkg::SCALE_DIV48: pre_ratio = tcs_pkg::DIV_48;
      default: pre_ratio = tcs_pkg::DIV_12; // code 11 undefined; falls back to /12
    endcase
  end

  tcs_divider u_pre (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step_en(1'b1),
    .ratio(pre_ratio),
    .tick(pre_tick)
  );

  tcs_divider u_div12 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step_en(1'b1),
    .ratio(tcs_pkg::DIV_12),
    .tick(div12_tick)
  );

  // rising edge of the sampled oscillator, then /8
  assign ext_edge = ext_osc & ~osc_q;

  tcs_divider u_ext8 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step_en(ext_edge),
    .ratio(tcs_pkg::DIV_EXT),
    .tick(ext_tick)
  );

  // edge count kept apart from the divider so the /8 check does not lean on the divider itself
  logic [2:0] edge_cnt_q;
  logic [2:0] edge_cnt_d;

  always_comb begin
    edge_cnt_d = edge_cnt_q;
    if (ext_edge) begin
      edge_cnt_d = edge_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      edge_cnt_q <= 3'h0;
    end else begin
      edge_cnt_q <= edge_cnt_d;
    end
  end

  assign alt2 = ext_q[tcs_pkg::BIT_T2_ALT] ? ext_tick : div12_tick;
  assign alt3 = ext_q[tcs_pkg::BIT_T3_ALT] ? ext_tick : div12_tick;

  // per-timer selection; counter mode forces zero ticks from this block
  always_comb begin
    tick_d.t0 = ext_q[tcs_pkg::BIT_T0_CNT] ? 1'b0 :
                (ctrl_q[tcs_pkg::BIT_T0] ? 1'b1 : pre_tick);
    tick_d.t1 = ext_q[tcs_pkg::BIT_T1_CNT] ? 1'b0 :
                (ctrl_q[tcs_pkg::BIT_T1] ? 1'b1 : pre_tick);
    tick_d.t2_low = ctrl_q[tcs_pkg::BIT_T2_LOW] ? 1'b1 : alt2;
    tick_d.t3_low = ctrl_q[tcs_pkg::BIT_T3_LOW] ? 1'b1 : alt3;
    // outside split mode the high byte follows the low select so it carries with it
    if (ext_q[tcs_pkg::BIT_T2_SPLIT]) begin
      tick_d.t2_high = ctrl_q[tcs_pkg::BIT_T2_HIGH] ? 1'b1 : alt2;
    end else begin
      tick_d.t2_high = tick_d.t2_low;
    end
    if (ext_q[tcs_pkg::BIT_T3_SPLIT]) begin
      tick_d.t3_high = ctrl_q[tcs_pkg::BIT_T3_HIGH] ? 1'b1 : alt3;
    end else begin
      tick_d.t3_high = tick_d.t3_low;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
  assign prescale_tick = pre_tick;

  // register port; ticks lag the register by one flop, hence the $past on selects
  chk_reset_zero: assert property (@(posedge ref_clk) !$past(resetn) |-> ctrl_q == 8'h00)
    else $error("control register not zero after reset");
  chk_reset_ticks: assert property (@(posedge ref_clk) !$past(resetn) |-> tick == '0 && !prescale_tick)
    else $error("ticks not quiet after reset");
  chk_write_store: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_en && addr == tcs_pkg::ADDR_CLK_CTRL |=> ctrl_q == $past(wdata))
    else $error("control write not stored");
  chk_write_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(wr_en && addr == tcs_pkg::ADDR_CLK_CTRL) |=> ctrl_q == $past(ctrl_q))
    else $error("control register changed without a write");
  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(rd_en) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_rdata_ctrl: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(rd_en) && $past(addr) == tcs_pkg::ADDR_CLK_CTRL |-> rdata == $past(ctrl_q))
    else $error("control read data wrong");
  chk_rdata_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(rd_en) && $past(addr) == tcs_pkg::ADDR_EXT_CTRL |-> rdata == {2'h0, $past(ext_q)})
    else $error("mode read data wrong");
  chk_rdata_unmapped: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(rd_en) && $past(addr) > tcs_pkg::ADDR_EXT_CTRL |-> rdata == 8'h00)
    else $error("unmapped read not zero");

  // timers 0 and 1
  chk_t0_counter: assert property (@(posedge ref_clk) disable iff (!resetn)
    ext_q[tcs_pkg::BIT_T0_CNT] && $past(ext_q[tcs_pkg::BIT_T0_CNT]) |-> !tick.t0)
    else $error("timer 0 ticked in counter mode");
  chk_t1_counter: assert property (@(posedge ref_clk) disable iff (!resetn)
    ext_q[tcs_pkg::BIT_T1_CNT] && $past(ext_q[tcs_pkg::BIT_T1_CNT]) |-> !tick.t1)
    else $error("timer 1 ticked in counter mode");
  chk_t0_system_clock: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(ctrl_q[tcs_pkg::BIT_T0]) && !$past(ext_q[tcs_pkg::BIT_T0_CNT]) |-> tick.t0)
    else $error("timer 0 missed system clock tick");
  chk_t0_prescale: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ctrl_q[tcs_pkg::BIT_T0]) && !$past(ext_q[tcs_pkg::BIT_T0_CNT]) |-> tick.t0 == $past(pre_tick))
    else $error("timer 0 not following prescaler");
  chk_t1_system_clock: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(ctrl_q[tcs_pkg::BIT_T1]) && !$past(ext_q[tcs_pkg::BIT_T1_CNT]) |-> tick.t1)
    else $error("timer 1 missed system clock tick");
  chk_t1_prescale: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ctrl_q[tcs_pkg::BIT_T1]) && !$past(ext_q[tcs_pkg::BIT_T1_CNT]) |-> tick.t1 == $past(pre_tick))
    else $error("timer 1 not following prescaler");
  chk_pre_shared: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ctrl_q[2]) && !$past(ctrl_q[3]) && !$past(ext_q[0]) && !$past(ext_q[1])
    |-> tick.t0 == tick.t1)
    else $error("timers 0 and 1 not sharing prescaler");

  // shared prescaler; a shrinking ratio may shorten one period, never below four cycles
  chk_pre_gap: assert property (@(posedge ref_clk) disable iff (!resetn)
    pre_tick |=> !pre_tick [*3])
    else $error("prescaler ticks too close");
  chk_div4_period: assert property (@(posedge ref_clk) disable iff (!resetn)
    pre_tick && pre_ratio == tcs_pkg::DIV_4 && $stable(pre_ratio) |-> ##4 (pre_tick || pre_ratio != tcs_pkg::DIV_4))
    else $error("divide by 4 period wrong");
  chk_div48_period: assert property (@(posedge ref_clk) disable iff (!resetn)
    pre_tick && pre_ratio == tcs_pkg::DIV_48 && $stable(pre_ratio)
    |-> ##48 (pre_tick || pre_ratio != tcs_pkg::DIV_48))
    else $error("divide by 48 period wrong");
  chk_div12_period: assert property (@(posedge ref_clk) disable iff (!resetn)
    pre_tick && pre_ratio == tcs_pkg::DIV_12 && $stable(pre_ratio)
    |-> ##12 (pre_tick || pre_ratio != tcs_pkg::DIV_12))
    else $error("divide by 12 prescale period wrong");
  chk_pre_reset12: assert property (@(posedge ref_clk) disable iff (!resetn)
    ctrl_q[1:0] == 2'h0 |-> pre_ratio == tcs_pkg::DIV_12)
    else $error("reset prescale not twelve");

  // alternate clocks
  chk_div12_gap: assert property (@(posedge ref_clk) disable iff (!resetn)
    div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
    else $error("divide by 12 period wrong");
  chk_div12_start: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> !div12_tick [*8] ##1 !div12_tick [*4] ##1 div12_tick)
    else $error("first divide by 12 tick misplaced");
  chk_ext_count: assert property (@(posedge ref_clk) disable iff (!resetn)
    ext_tick |-> $past(ext_edge) && $past(edge_cnt_q) == 3'h7)
    else $error("external tick not on eighth edge");
  chk_ext_eighth: assert property (@(posedge ref_clk) disable iff (!resetn)
    ext_edge && edge_cnt_q == 3'h7 |=> ext_tick)
    else $error("eighth external edge gave no tick");
  chk_ext_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ext_edge) |-> !ext_tick)
    else $error("external tick without an edge");
  chk_t2_alt_ext: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ctrl_q[tcs_pkg::BIT_T2_LOW]) && $past(ext_q[tcs_pkg::BIT_T2_ALT]) |-> tick.t2_low == $past(ext_tick))
    else $error("timer 2 low not on external clock");
  chk_t2_alt_div12: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ctrl_q[tcs_pkg::BIT_T2_LOW]) && !$past(ext_q[tcs_pkg::BIT_T2_ALT]) |-> tick.t2_low == $past(div12_tick))
    else $error("timer 2 low not on divide by 12");
  chk_t3_alt_ext: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ctrl_q[tcs_pkg::BIT_T3_LOW]) && $past(ext_q[tcs_pkg::BIT_T3_ALT]) |-> tick.t3_low == $past(ext_tick))
    else $error("timer 3 low not on external clock");
  chk_t3_alt_div12: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ctrl_q[tcs_pkg::BIT_T3_LOW]) && !$past(ext_q[tcs_pkg::BIT_T3_ALT]) |-> tick.t3_low == $past(div12_tick))
    else $error("timer 3 low not on divide by 12");

  // timers 2 and 3
  chk_t2_whole: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ext_q[tcs_pkg::BIT_T2_SPLIT]) |-> tick.t2_high == tick.t2_low)
    else $error("timer 2 bytes split outside split mode");
  chk_t3_whole: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ext_q[tcs_pkg::BIT_T3_SPLIT]) |-> tick.t3_high == tick.t3_low)
    else $error("timer 3 bytes split outside split mode");
  chk_t3_high_sys: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(ext_q[tcs_pkg::BIT_T3_SPLIT]) && $past(ctrl_q[tcs_pkg::BIT_T3_HIGH]) |-> tick.t3_high)
    else $error("timer 3 high missed system tick");
  chk_t3_low_sys: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(ctrl_q[tcs_pkg::BIT_T3_LOW]) |-> tick.t3_low)
    else $error("timer 3 low missed system tick");
  chk_t2_high_sys: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(ext_q[tcs_pkg::BIT_T2_SPLIT]) && $past(ctrl_q[tcs_pkg::BIT_T2_HIGH]) |-> tick.t2_high)
    else $error("timer 2 high missed system tick");
  chk_t2_low_sys: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(ctrl_q[tcs_pkg::BIT_T2_LOW]) |-> tick.t2_low)
    else $error("timer 2 low missed system tick");
  chk_t2_high_alt: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(ext_q[tcs_pkg::BIT_T2_SPLIT]) && !$past(ctrl_q[tcs_pkg::BIT_T2_HIGH]) |-> tick.t2_high == $past(alt2))
    else $error("timer 2 high not on alternate clock");
  chk_t3_high_alt: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(ext_q[tcs_pkg::BIT_T3_SPLIT]) && !$past(ctrl_q[tcs_pkg::BIT_T3_HIGH]) |-> tick.t3_high == $past(alt3))
    else $error("timer 3 high not on alternate clock");
  // outside split mode a set high select must change nothing
  chk_t2_high_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ext_q[tcs_pkg::BIT_T2_SPLIT]) && $past(ctrl_q[tcs_pkg::BIT_T2_HIGH])
    && !$past(ctrl_q[tcs_pkg::BIT_T2_LOW]) |-> tick.t2_high == $past(alt2))
    else $error("timer 2 high select not ignored");
  chk_t3_high_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(ext_q[tcs_pkg::BIT_T3_SPLIT]) && $past(ctrl_q[tcs_pkg::BIT_T3_HIGH])
    && !$past(ctrl_q[tcs_pkg::BIT_T3_LOW]) |-> tick.t3_high == $past(alt3))
    else $error("timer 3 high select not ignored");
endmodule : tcs_clock_select

// ### verif/tcs_clock_select_test.sv
// testbench for tcs_clock_select: register port checks and tick rate counts
// assumes the package register map and one-cycle tick enables on ref_clk
`timescale 1ns/1ps
module tcs_clock_select_test;
  localparam logic [7:0] P1 = 8'h60;
  localparam logic [7:0] P4 = 8'h18;
  localparam logic [7:0] P12 = 8'h08;
  localparam logic [7:0] P48 = 8'h02;
  localparam logic [7:0] PX = 8'h06;
  localparam logic [7:0] P0 = 8'h00;
  localparam logic [3:0] CTL = tcs_pkg::ADDR_CLK_CTRL;
  localparam logic [3:0] EXT = tcs_pkg::ADDR_EXT_CTRL;
  logic ref_clk, resetn, wr_en, rd_en, ext_osc, prescale_tick;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, got;
  tcs_pkg::tcs_tick_t tick;
  logic [6:0] taps;
  logic [6:0][7:0] cnt;
  int failures, n_compared;

  assign taps = {prescale_tick, tick};

  tcs_clock_select tcs_clock_select_inst (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ext_osc(ext_osc), .tick(tick), .prescale_tick(prescale_tick)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // oscillator toggles every cycle, so eight rising edges span 16 cycles
  always @(posedge ref_clk) ext_osc <= ~ext_osc;

  task chk8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk8

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 got = rdata;
  endtask : rd

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task regs;
    rd(CTL);
    chk8("ctrl reset", tcs_pkg::CLK_CTRL_RESET, got);
    rd(EXT);
    chk8("mode reset", tcs_pkg::EXT_CTRL_RESET, got);
    wr(CTL, 8'ha5);
    rd(CTL);
    chk8("ctrl a5", 8'ha5, got);
    wr(CTL, 8'h5a);
    rd(CTL);
    chk8("ctrl 5a", 8'h5a, got);
    wr(4'h7, 8'hff);
    rd(4'h7);
    chk8("unmapped", 8'h00, got);
    rd(CTL);
    chk8("ctrl kept", 8'h5a, got);
    wr(EXT, 8'hff);
    rd(EXT);
    chk8("mode bits", 8'h3f, got);
    $display("done regs");
  endtask : regs

  // window of 96 cycles is a whole number of every period in use
  task rate(input string name, input logic [7:0] ctrl, input logic [7:0] mode, input logic [6:0][7:0] exp);
    wr(CTL, ctrl);
    wr(EXT, mode);
    repeat (24) @(posedge ref_clk);
    cnt = '0;
    repeat (96) begin
      @(posedge ref_clk);
      #1;
      for (int i = 0; i < 7; i++) cnt[i] = cnt[i] + {7'h00, taps[i]};
    end
    for (int i = 0; i < 7; i++) chk8($sformatf("%s tap %0d", name, i), exp[i], cnt[i]);
    $display("done %s", name);
  endtask : rate

  initial begin
    resetn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ext_osc = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    failures = 0;
    n_compared = 0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    regs;
    rate("reset", 8'h00, 8'h00, {P12, P12, P12, P12, P12, P12, P12});
    rate("div4", 8'h09, 8'h00, {P4, P12, P12, P12, P12, P1, P4});
    rate("div48", 8'h06, 8'h00, {P48, P12, P12, P12, P12, P48, P1});
    rate("counter", 8'h0f, 8'h03, {P12, P12, P12, P12, P12, P0, P0});
    rate("nosplit_hi", 8'ha0, 8'h00, {P12, P12, P12, P12, P12, P12, P12});
    rate("nosplit_lo", 8'h50, 8'h00, {P12, P1, P1, P1, P1, P12, P12});
    rate("split_hi", 8'ha0, 8'h0c, {P12, P1, P12, P1, P12, P12, P12});
    rate("split_alt", 8'h50, 8'h3c, {P12, PX, P1, PX, P1, P12, P12});
    rate("alt_whole", 8'h00, 8'h30, {P12, PX, PX, PX, PX, P12, P12});
    stop_test;
  end

  // tests need about 1160 cycles; this limit only cuts a hang short
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    stop_test;
  end
endmodule : tcs_clock_select_test
